// file: include/dacpr_pkg.sv
package dacpr_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int MIN_LOW_CYCLES = 4;
  localparam int POP_SETTLE_NS = 10000;
  localparam int POP_SETTLE_CYCLES = (POP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CTRL_LEFT = 8'h00;
  localparam logic [7:0] ADDR_CTRL_RIGHT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CONFIG = 8'h0c;
  localparam int MUTE_BIT = 6;
  localparam int ATTEN_W = 6;
  localparam logic CHAN_MUTE_RESET = 1'b0;
  localparam logic [ATTEN_W-1:0] CHAN_ATTEN_RESET = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_POWERDOWN = 2'b00,
    ST_WAKE = 2'b01,
    ST_RUN = 2'b10
  } dacpr_state_t;

  typedef struct packed {
    logic mute;
    logic [ATTEN_W-1:0] atten;
  } dacpr_chan_t;

  typedef struct packed {
    logic [1:0] input_format;
    logic word_width_18;
    logic deemphasis_enable;
  } dacpr_cfg_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } dacpr_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } dacpr_axil_rsp_t;

endpackage

// file: rtl/dacpr_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
module dacpr_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dacpr_sync_st_t;

  dacpr_sync_st_t st;
  dacpr_sync_st_t next_st;

  // First stage feeds only the second
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule

// file: rtl/dacpr_top.sv
module dacpr_top #(
  parameter int SETTLE_CYCLES = dacpr_pkg::POP_SETTLE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dacpr_pkg::dacpr_axil_req_t axil_req,
  output dacpr_pkg::dacpr_axil_rsp_t axil_rsp,
  input wire logic powerdown_reset_n,
  input wire logic input_format_select0,
  input wire logic input_format_select1,
  input wire logic word_width_18,
  input wire logic deemphasis_enable,
  output logic engine_run,
  output logic engine_clear,
  output logic amp_short,
  output logic device_ready,
  output dacpr_pkg::dacpr_chan_t chan_left,
  output dacpr_pkg::dacpr_chan_t chan_right,
  output dacpr_pkg::dacpr_cfg_t cfg_out
);
  import dacpr_pkg::*;

  localparam int SW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [SW-1:0] SETTLE_LOAD = SW'(SETTLE_CYCLES);
  localparam logic [2:0] LOW_LAST = 3'(MIN_LOW_CYCLES - 1);

  typedef struct packed {
    dacpr_state_t state;
    logic [2:0] low_cnt;
    logic [SW-1:0] settle_cnt;
    logic engine_run;
    logic engine_clear;
    logic amp_short;
    logic ready;
    dacpr_chan_t left;
    dacpr_chan_t right;
    dacpr_cfg_t cfg;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dacpr_top_st_t;

  dacpr_top_st_t st;
  dacpr_top_st_t next_st;
  logic pd_s;
  dacpr_cfg_t cfg_s;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  dacpr_sync #(.W(1)) u_sync_pd (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(powerdown_reset_n),
    .q(pd_s)
  );

  dacpr_sync #(.W(4)) u_sync_cfg (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({input_format_select1, input_format_select0, word_width_18, deemphasis_enable}),
    .q(cfg_s)
  );

  // ****************************************
  // Sequencer and register file
  // ****************************************
  always_comb begin
    logic do_write;
    logic [7:0] ra;
    do_write = 1'b0;
    ra = axil_req.araddr;
    next_st = st;
    next_st.cfg = cfg_s; // Live pins, no reset needed

    // Count consecutive low cycles of the synced pin
    if (pd_s) begin
      next_st.low_cnt = 3'h0;
    end else if (st.low_cnt != 3'h7) begin
      next_st.low_cnt = st.low_cnt + 3'h1;
    end

    unique case (st.state)
      ST_POWERDOWN: begin
        if (pd_s) begin
          next_st.state = ST_WAKE;
          next_st.settle_cnt = SETTLE_LOAD;
        end
      end
      ST_WAKE: begin
        // Engine runs with amps still shorted so the start-up step is absorbed
        if (st.settle_cnt == '0) begin
          next_st.state = ST_RUN;
        end else begin
          next_st.settle_cnt = st.settle_cnt - SW'(1);
        end
      end
      ST_RUN: ;
      // Unused code falls back to the safe, shorted state
      default: next_st.state = ST_POWERDOWN;
    endcase

    // A low of the minimum width forces power-down from any state
    if (!pd_s && st.low_cnt >= LOW_LAST) begin
      next_st.state = ST_POWERDOWN;
    end

    // Outputs follow the next state so they stay in step with it
    next_st.engine_run = next_st.state != ST_POWERDOWN;
    next_st.engine_clear = next_st.state == ST_POWERDOWN;
    next_st.amp_short = next_st.state != ST_RUN;
    next_st.ready = next_st.state == ST_RUN;

    // Write address and data are taken in either order
    if (axil_req.awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = axil_req.awaddr;
    end
    if (axil_req.wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.wdata = axil_req.wdata;
      next_st.wstrb = axil_req.wstrb;
    end
    if (st.bvalid && axil_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      do_write = 1'b1;
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      unique case (st.awaddr)
        ADDR_CTRL_LEFT: ;
        ADDR_CTRL_RIGHT: ;
        ADDR_STATUS: ;
        ADDR_CONFIG: ;
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end
    // Writes are dropped while powered down; defaults win
    if (do_write && st.wstrb[0] && next_st.state != ST_POWERDOWN) begin
      if (st.awaddr == ADDR_CTRL_LEFT) begin
        next_st.left = {st.wdata[MUTE_BIT], st.wdata[ATTEN_W-1:0]};
      end
      if (st.awaddr == ADDR_CTRL_RIGHT) begin
        next_st.right = {st.wdata[MUTE_BIT], st.wdata[ATTEN_W-1:0]};
      end
    end
    if (next_st.state == ST_POWERDOWN) begin
      next_st.left = {CHAN_MUTE_RESET, CHAN_ATTEN_RESET};
      next_st.right = {CHAN_MUTE_RESET, CHAN_ATTEN_RESET};
    end

    // Read channel
    if (st.rvalid && axil_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axil_req.arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h0;
      unique case (ra)
        ADDR_CTRL_LEFT: next_st.rdata = {25'h0, st.left};
        ADDR_CTRL_RIGHT: next_st.rdata = {25'h0, st.right};
        ADDR_STATUS: next_st.rdata = {27'h0, st.amp_short, st.ready, st.engine_run, st.state};
        ADDR_CONFIG: next_st.rdata = {28'h0, st.cfg};
        default: next_st.rresp = RESP_SLVERR;
      endcase
    end
  end

  // Bus reset starts powered down; the pin decides when to wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.state <= ST_POWERDOWN;
      st.engine_clear <= 1'b1;
      st.amp_short <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    axil_rsp.awready = !st.aw_held;
    axil_rsp.wready = !st.w_held;
    axil_rsp.bvalid = st.bvalid;
    axil_rsp.bresp = st.bresp;
    axil_rsp.arready = !st.rvalid;
    axil_rsp.rvalid = st.rvalid;
    axil_rsp.rdata = st.rdata;
    axil_rsp.rresp = st.rresp;
  end

  assign engine_run = st.engine_run;
  assign engine_clear = st.engine_clear;
  assign amp_short = st.amp_short;
  assign device_ready = st.ready;
  assign chan_left = st.left;
  assign chan_right = st.right;
  assign cfg_out = st.cfg;

  // ****************************************
  // Assertions
  // ****************************************
  property p_pd_idle;
    @(posedge aclk) disable iff (!aresetn) (st.state == ST_POWERDOWN) |-> !engine_run && !device_ready;
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("engine active in power-down");

  property p_wake_on_high;
    @(posedge aclk) disable iff (!aresetn) (st.state == ST_POWERDOWN && pd_s) |=> (st.state == ST_WAKE) && engine_run;
  endproperty
  a_wake_on_high: assert property (p_wake_on_high) else $error("no wake after pin high");

  property p_min_pulse;
    @(posedge aclk) disable iff (!aresetn) (!pd_s)[*4] |=> (st.state == ST_POWERDOWN) && engine_clear;
  endproperty
  a_min_pulse: assert property (p_min_pulse) else $error("four-cycle low not honoured");

  property p_clear_short;
    @(posedge aclk) disable iff (!aresetn) engine_clear |-> amp_short && !engine_run;
  endproperty
  a_clear_short: assert property (p_clear_short) else $error("datapath clear without amp short");

  property p_chan_default;
    @(posedge aclk) disable iff (!aresetn) $rose(engine_clear) |-> chan_left == 7'h00 && chan_right == 7'h00;
  endproperty
  a_chan_default: assert property (p_chan_default) else $error("channel defaults not loaded");

  property p_atten_zero;
    @(posedge aclk) disable iff (!aresetn) engine_clear |-> !chan_left.mute && !chan_right.mute
      && chan_left.atten == CHAN_ATTEN_RESET && chan_right.atten == CHAN_ATTEN_RESET;
  endproperty
  a_atten_zero: assert property (p_atten_zero) else $error("default not unmuted zero atten");

  property p_cfg_follow;
    @(posedge aclk) disable iff (!aresetn) ##1 cfg_out == $past(cfg_s);
  endproperty
  a_cfg_follow: assert property (p_cfg_follow) else $error("config pins not tracked");

  property p_unshort_late;
    @(posedge aclk) disable iff (!aresetn) $fell(amp_short) |-> $past(st.settle_cnt) == '0 && $past(engine_run);
  endproperty
  a_unshort_late: assert property (p_unshort_late) else $error("amps unshorted before settle");

  property p_count_first;
    @(posedge aclk) disable iff (!aresetn) $rose(engine_clear) |-> $past(st.low_cnt) >= LOW_LAST;
  endproperty
  a_count_first: assert property (p_count_first) else $error("power-down without low count");

  c_powerdown: cover property (@(posedge aclk) disable iff (!aresetn) $rose(engine_clear));
  c_ready: cover property (@(posedge aclk) disable iff (!aresetn) $rose(device_ready));
  c_write: cover property (@(posedge aclk) disable iff (!aresetn) st.bvalid && axil_req.bready);
  c_short_glitch: cover property (@(posedge aclk) disable iff (!aresetn) device_ready && !pd_s ##1 pd_s);
endmodule

// file: sim/dacpr_host_model.sv
// Host side: drives the power-down pin and the configuration pins
module dacpr_host_model (
  input wire logic aclk,
  output logic powerdown_reset_n,
  output logic [3:0] cfg_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // Start held in power-down; the clock is never gated here
  initial begin
    powerdown_reset_n = 1'b0;
    cfg_pins = 4'h0;
  end

  // Release, then keep the ports quiet while the device relocks
  task automatic release_pin(input int relock);
    @(posedge aclk);
    powerdown_reset_n <= 1'b1;
    repeat (relock) @(posedge aclk);
  endtask

  // Low pulse of n whole clocks; clock keeps running throughout
  task automatic pulse(input int n);
    @(posedge aclk);
    powerdown_reset_n <= 1'b0;
    repeat (n - 1) @(posedge aclk);
    release_pin(0);
  endtask

  // Pins settle well before any word would use them
  task automatic set_cfg(input logic [3:0] v);
    @(posedge aclk);
    cfg_pins <= v;
    repeat (4) @(posedge aclk);
  endtask
endmodule

// file: sim/dacpr_top_bench.sv
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, s); end end

module dacpr_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dacpr_pkg::*;

  localparam int SETTLE = 4;
  logic aclk, aresetn, engine_run, engine_clear, amp_short, device_ready, pd_n;
  logic [3:0] cfg;
  logic [6:0] vl, vr;
  dacpr_axil_req_t req;
  dacpr_axil_rsp_t rsp;
  dacpr_chan_t chan_left, chan_right;
  dacpr_cfg_t cfg_out;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int n_mismatch, comparisons, t;

  dacpr_top #(.SETTLE_CYCLES(SETTLE)) u_dacpr_top (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
    .axil_rsp(rsp), .powerdown_reset_n(pd_n), .input_format_select0(cfg[2]), .input_format_select1(cfg[3]),
    .word_width_18(cfg[1]), .deemphasis_enable(cfg[0]), .engine_run(engine_run), .engine_clear(engine_clear),
    .amp_short(amp_short), .device_ready(device_ready), .chan_left(chan_left), .chan_right(chan_right),
    .cfg_out(cfg_out));
  dacpr_host_model u_dacpr_host_model (.aclk(aclk), .powerdown_reset_n(pd_n), .cfg_pins(cfg));

  // ****************
  // Clock, verdict and bus tasks
  // ****************
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic conclude;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // A spent wait counts against the run and stops it
  task automatic guard(input int n);
    if (n >= 60) begin
      n_mismatch++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    k = 0;
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      k++;
    end while (!rsp.bvalid && k < 60);
    req.bready <= 1'b0;
    guard(k);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
    int k;
    k = 0;
    exp_q.push_back({r, d});
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      k++;
    end while (!rsp.rvalid && k < 60);
    req.rready <= 1'b0;
    guard(k);
  endtask

  // Each answer is matched against the oldest note
  always @(posedge aclk) begin
    if (req.bready && rsp.bvalid && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK("bresp", e[33:32], rsp.bresp)
    end
    if (req.rready && rsp.rvalid && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK("read", e, {rsp.rresp, rsp.rdata})
    end
  end

  // Power-down seen, then amps stay shorted through the settle time
  task automatic wake;
    t = 0;
    while (engine_run !== 1'b0 && t < 60) begin
      @(posedge aclk);
      t++;
    end
    guard(t);
    `CHK("clear", 1'b1, engine_clear)
    t = 0;
    while (engine_run !== 1'b1 && t < 60) begin
      @(posedge aclk);
      t++;
    end
    guard(t);
    `CHK("amp in wake", 1'b1, amp_short)
    t = 0;
    while (device_ready !== 1'b1 && t < 60) begin
      @(posedge aclk);
      t++;
    end
    guard(t);
    `CHK("wake length", SETTLE + 1, t)
    `CHK("amp in run", 1'b0, amp_short)
  endtask

  // ****************
  // Scenarios
  // ****************
  initial begin
    void'($urandom(32'hf09b));
    aresetn = 1'b0;
    req = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    `CHK("run in pd", 1'b0, engine_run)
    `CHK("amp in pd", 1'b1, amp_short)
    rd(ADDR_STATUS, RESP_OKAY, 32'h10);
    wr(ADDR_CTRL_LEFT, 32'h7f, RESP_OKAY);
    rd(ADDR_CTRL_LEFT, RESP_OKAY, 32'h0);
    u_dacpr_host_model.release_pin(0);
    wake();
    rd(ADDR_STATUS, RESP_OKAY, 32'h0e);
    // Host keeps both outputs muted while the clock tracking settles
    wr(ADDR_CTRL_LEFT, 32'h40, RESP_OKAY);
    wr(ADDR_CTRL_RIGHT, 32'h40, RESP_OKAY);
    rd(ADDR_CTRL_LEFT, RESP_OKAY, 32'h40);
    vl = 7'($urandom);
    vr = 7'($urandom);
    wr(ADDR_CTRL_LEFT, {25'h0, vl}, RESP_OKAY);
    wr(ADDR_CTRL_RIGHT, {25'h0, vr}, RESP_OKAY);
    rd(ADDR_CTRL_RIGHT, RESP_OKAY, {25'h0, vr});
    // Too short a pulse leaves the engine running and settings intact
    u_dacpr_host_model.pulse(3);
    t = 0;
    repeat (10) begin
      @(posedge aclk);
      if (engine_run !== 1'b1) t++;
    end
    `CHK("short pulse", 0, t)
    `CHK("left kept", vl, chan_left)
    u_dacpr_host_model.pulse(4);
    wake();
    `CHK("left default", 7'h00, chan_left)
    `CHK("right default", 7'h00, chan_right)
    rd(ADDR_CTRL_LEFT, RESP_OKAY, 32'h0);
    repeat (4) begin
      u_dacpr_host_model.set_cfg(4'($urandom));
      `CHK("cfg pins", cfg, cfg_out)
      rd(ADDR_CONFIG, RESP_OKAY, {28'h0, cfg});
    end
    rd(8'h10, RESP_SLVERR, 32'h0);
    wr(8'h14, 32'h1, RESP_SLVERR);
    repeat (4) @(posedge aclk);
    conclude();
  end
endmodule
